/* inc/sfcfe_defines.svh */
// Constants of the serial flash command front end
// How it works
// - Erase in 4k, 32k, 64k, chip sizes
// - Erase blocks aligned to their own size
// - Sample on rising edge, drive on falling
// - Dual output drives both serial lines
// - Dual I/O: opcode single, address two-wide
// - Quad output drives all four lines
// - Quad I/O turns lines around after address
// - All fields travel most significant bit first
// - Raising chip select ends the operation
// - Unknown opcode ignored until next frame
// - Incomplete header performs nothing, back idle
// - Three address bytes, top bit ignored
// - Opcode takes eight single-lane clocks except in continuous frames; address clocks follow lane width
// - Data byte clocks follow lane width
// - Mode field after address for BB, EB, E7
// - Continuous mode skips the opcode phase
// - Fast read dummy clock counts per opcode
// - Dummy clocks for parameter, dual and quad ID, and unique ID reads
// - Opcode only commands carry nothing more
// - Sector and block erases carry address, no data; chip erase is opcode only
// - Status accesses move bytes until deselect, no address
// - Upper lines are data only when enabled
// - Serial out released while deselected
`ifndef SFCFE_DEFINES_SVH
`define SFCFE_DEFINES_SVH

// ----------------------------------------
// Field sizes and lane codes
// ----------------------------------------
`define SFCFE_OP_BITS 8
`define SFCFE_ADDR_BITS 24
`define SFCFE_BYTE_BITS 8
`define SFCFE_ADDR_W 23
`define SFCFE_LG1 2'h0
`define SFCFE_LG2 2'h1
`define SFCFE_LG4 2'h2
`define SFCFE_PIN_IDLE 6'h3F
`define SFCFE_CONT_MODE 2'h2

// ----------------------------------------
// Mode and dummy clock counts
// ----------------------------------------
`define SFCFE_MODE_NONE 3'h0
`define SFCFE_MODE_DIO 3'h4
`define SFCFE_MODE_QIO 3'h2
`define SFCFE_DUMMY_NONE 6'h00
`define SFCFE_DUMMY_FAST 6'h08
`define SFCFE_DUMMY_QIO 6'h04
`define SFCFE_DUMMY_WORD 6'h02
`define SFCFE_DUMMY_ID 6'h04
`define SFCFE_DUMMY_UID 6'h20
`define SFCFE_DUMMY_BURST 6'h06

// ----------------------------------------
// Erase alignment masks
// ----------------------------------------
`define SFCFE_ER4K_MASK 23'h7F_F000
`define SFCFE_ER32K_MASK 23'h7F_8000
`define SFCFE_ER64K_MASK 23'h7F_0000

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFCFE_OP_RST_EN 8'h66
`define SFCFE_OP_RST 8'h99
`define SFCFE_OP_PWR_DN 8'hB9
`define SFCFE_OP_PWR_UP 8'hAB
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST 8'h0B
`define SFCFE_OP_DOUT 8'h3B
`define SFCFE_OP_DIO 8'hBB
`define SFCFE_OP_QOUT 8'h6B
`define SFCFE_OP_QIO 8'hEB
`define SFCFE_OP_WORD 8'hE7
`define SFCFE_OP_BURST 8'h77
`define SFCFE_OP_WREN 8'h06
`define SFCFE_OP_VWREN 8'h50
`define SFCFE_OP_WRDI 8'h04
`define SFCFE_OP_PROG 8'h02
`define SFCFE_OP_QPROG 8'h32
`define SFCFE_OP_ER4K 8'h20
`define SFCFE_OP_ER32K 8'h52
`define SFCFE_OP_ER64K 8'hD8
`define SFCFE_OP_CHIP_A 8'hC7
`define SFCFE_OP_CHIP_B 8'h60
`define SFCFE_OP_SUSP 8'h75
`define SFCFE_OP_RESUME 8'h7A
`define SFCFE_OP_RSR1 8'h05
`define SFCFE_OP_RSR2 8'h35
`define SFCFE_OP_RSR3 8'h15
`define SFCFE_OP_WSR1 8'h01
`define SFCFE_OP_WSR2 8'h31
`define SFCFE_OP_WSR3 8'h11
`define SFCFE_OP_ID 8'h90
`define SFCFE_OP_ID_DIO 8'h92
`define SFCFE_OP_ID_QIO 8'h94
`define SFCFE_OP_JID 8'h9F
`define SFCFE_OP_PARAM 8'h5A
`define SFCFE_OP_SEC_ER 8'h44
`define SFCFE_OP_SEC_PG 8'h42
`define SFCFE_OP_SEC_RD 8'h48
`define SFCFE_OP_UID 8'h4B

`endif

/* inc/sfcfe_pkg.sv */
// Types of the serial flash command front end
package sfcfe_pkg;
`include "sfcfe_defines.svh"

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_OP, ST_ADDR, ST_MODE, ST_DUMMY,
		ST_DIN, ST_DOUT, ST_DONE, ST_IGN
	} sfcfe_state_e;
	typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} sfcfe_dir_e;
	typedef enum logic [1:0] {ER_4K, ER_32K, ER_64K, ER_CHIP} sfcfe_erase_e;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic ok;
		logic quad;
		logic has_addr;
		logic [1:0] ad_lg;
		logic [2:0] mode_clk;
		logic [5:0] dummy_clk;
		sfcfe_dir_e dir;
		logic [1:0] da_lg;
	} sfcfe_phase_width_code_s;
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic [3:0] io;
	} sfcfe_pins_s;
	typedef struct packed {
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} sfcfe_drive_s;
	typedef struct packed {
		logic start;
		logic done;
		logic cont;
		logic [7:0] opcode;
		logic [`SFCFE_ADDR_W-1:0] addr;
	} sfcfe_cmd_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sfcfe_rx_s;
	typedef struct packed {
		logic valid;
		sfcfe_erase_e size;
		logic [`SFCFE_ADDR_W-1:0] base;
	} sfcfe_erase_s;

	// Whole state of the front end
	typedef struct packed {
		sfcfe_state_e state;
		logic sck_p;
		logic [5:0] cnt;
		logic [23:0] sh;
		sfcfe_phase_width_code_s desc;
		logic [7:0] opcode;
		logic [`SFCFE_ADDR_W-1:0] addr;
		logic cont;
		logic [7:0] cont_op;
		logic frame_cont;
		logic hdr;
		logic armed;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		sfcfe_drive_s drv;
		logic cmd_start;
		logic cmd_done;
		logic tx_next;
		sfcfe_rx_s rx;
		sfcfe_erase_s er;
		logic rst_p;
		logic [7:0] rise_cnt;
	} sfcfe_fe_s;
endpackage

/* src/sfcfe_decode.sv */
// Opcode table: transfer shape of each supported command
`timescale 1ns/1ps
`include "sfcfe_defines.svh"
module sfcfe_decode (
	input wire logic [7:0] opcode,
	input wire logic quad_enable_bit,
	output sfcfe_pkg::sfcfe_phase_width_code_s desc
);
	import sfcfe_pkg::*;

	// Build one table entry; quad marks use of the upper lanes
	function automatic sfcfe_phase_width_code_s mk(input logic a,
		input logic [1:0] alg, input logic [2:0] m,
		input logic [5:0] dm, input sfcfe_dir_e dr,
		input logic [1:0] dlg);
		sfcfe_phase_width_code_s r;
		r.ok = 1'h1;
		r.has_addr = a;
		r.ad_lg = alg;
		r.mode_clk = m;
		r.dummy_clk = dm;
		r.dir = dr;
		r.da_lg = dlg;
		r.quad = (alg == `SFCFE_LG4) || (dlg == `SFCFE_LG4);
		return r;
	endfunction

	// Table lookup; anything unlisted stays not ok
	always_comb begin
		desc = '0;
		case (opcode)
			`SFCFE_OP_RST_EN, `SFCFE_OP_RST, `SFCFE_OP_PWR_DN,
			`SFCFE_OP_PWR_UP, `SFCFE_OP_WREN, `SFCFE_OP_VWREN,
			`SFCFE_OP_WRDI, `SFCFE_OP_CHIP_A, `SFCFE_OP_CHIP_B,
			`SFCFE_OP_SUSP, `SFCFE_OP_RESUME: begin
				desc = mk(1'h0, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_NONE, `SFCFE_LG1);
			end
			`SFCFE_OP_READ, `SFCFE_OP_ID: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_OUT, `SFCFE_LG1);
			end
			`SFCFE_OP_FAST, `SFCFE_OP_PARAM, `SFCFE_OP_SEC_RD: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_FAST, DIR_OUT, `SFCFE_LG1);
			end
			`SFCFE_OP_DOUT: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_FAST, DIR_OUT, `SFCFE_LG2);
			end
			`SFCFE_OP_QOUT: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_FAST, DIR_OUT, `SFCFE_LG4);
			end
			`SFCFE_OP_DIO: begin
				desc = mk(1'h1, `SFCFE_LG2, `SFCFE_MODE_DIO,
					`SFCFE_DUMMY_NONE, DIR_OUT, `SFCFE_LG2);
			end
			`SFCFE_OP_QIO: begin
				desc = mk(1'h1, `SFCFE_LG4, `SFCFE_MODE_QIO,
					`SFCFE_DUMMY_QIO, DIR_OUT, `SFCFE_LG4);
			end
			`SFCFE_OP_WORD: begin
				desc = mk(1'h1, `SFCFE_LG4, `SFCFE_MODE_QIO,
					`SFCFE_DUMMY_WORD, DIR_OUT, `SFCFE_LG4);
			end
			`SFCFE_OP_BURST: begin
				desc = mk(1'h0, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_BURST, DIR_IN, `SFCFE_LG4);
			end
			`SFCFE_OP_PROG, `SFCFE_OP_SEC_PG: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_IN, `SFCFE_LG1);
			end
			`SFCFE_OP_QPROG: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_IN, `SFCFE_LG4);
			end
			`SFCFE_OP_ER4K, `SFCFE_OP_ER32K, `SFCFE_OP_ER64K,
			`SFCFE_OP_SEC_ER: begin
				desc = mk(1'h1, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_NONE, `SFCFE_LG1);
			end
			`SFCFE_OP_RSR1, `SFCFE_OP_RSR2, `SFCFE_OP_RSR3,
			`SFCFE_OP_JID: begin
				desc = mk(1'h0, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_OUT, `SFCFE_LG1);
			end
			`SFCFE_OP_WSR1, `SFCFE_OP_WSR2, `SFCFE_OP_WSR3: begin
				desc = mk(1'h0, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_NONE, DIR_IN, `SFCFE_LG1);
			end
			`SFCFE_OP_ID_DIO: begin
				desc = mk(1'h1, `SFCFE_LG2, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_ID, DIR_OUT, `SFCFE_LG2);
			end
			`SFCFE_OP_ID_QIO: begin
				desc = mk(1'h1, `SFCFE_LG4, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_ID, DIR_OUT, `SFCFE_LG4);
			end
			`SFCFE_OP_UID: begin
				desc = mk(1'h0, `SFCFE_LG1, `SFCFE_MODE_NONE,
					`SFCFE_DUMMY_UID, DIR_OUT, `SFCFE_LG1);
			end
			default: begin
				desc = '0;
			end
		endcase
		// Quad commands are refused while the upper lanes are pins
		if (desc.quad && !quad_enable_bit) begin
			desc.ok = 1'h0;
		end
	end
endmodule

/* src/sfcfe_front_end.sv */
// Serial flash command front end: framing, decode, lane control
`timescale 1ns/1ps
`include "sfcfe_defines.svh"
module sfcfe_front_end (
	input wire logic clock,
	input wire logic sys_rst,
	input wire sfcfe_pkg::sfcfe_pins_s pins_in,
	input wire logic quad_enable_bit,
	input wire logic [7:0] tx_data,
	output sfcfe_pkg::sfcfe_drive_s pins_out,
	output logic protect_n,
	output logic pause_n,
	output sfcfe_pkg::sfcfe_cmd_s cmd,
	output logic tx_next,
	output sfcfe_pkg::sfcfe_rx_s rx,
	output sfcfe_pkg::sfcfe_erase_s erase,
	output logic dev_reset
);
	import sfcfe_pkg::*;

	logic [5:0] pin_f;
	sfcfe_pins_s pf;
	logic rise;
	logic fall;
	logic [7:0] op_cand;
	sfcfe_phase_width_code_s desc_cand;
	logic [1:0] lg;
	logic [23:0] bits;
	logic [7:0] cur;
	sfcfe_fe_s st;
	sfcfe_fe_s n;

	// ----------------------------------------
	// Pin capture and decode
	// ----------------------------------------

	// Every pin, clock included, is sampled by the system clock
	sfcfe_sync #(
		.W(6),
		.RST_VAL(`SFCFE_PIN_IDLE)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.d_in(pins_in),
		.d_out(pin_f)
	);

	// Edges of the filtered serial clock
	assign pf = sfcfe_pins_s'(pin_f);
	assign rise = pf.sck & ~st.sck_p;
	assign fall = ~pf.sck & st.sck_p;

	// Idle looks up the remembered continuous opcode, else the
	// opcode being completed on this rising edge
	assign op_cand = (st.state == ST_IDLE) ? st.cont_op : bits[7:0];

	sfcfe_decode u_dec (
		.opcode(op_cand),
		.quad_enable_bit(quad_enable_bit),
		.desc(desc_cand)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Shift in one clock worth of bits, first bit lands highest
	function automatic logic [23:0] shin(input logic [23:0] s,
		input logic [3:0] io, input logic [1:0] w);
		case (w)
			`SFCFE_LG2: shin = {s[21:0], io[1:0]};
			`SFCFE_LG4: shin = {s[19:0], io};
			default: shin = {s[22:0], io[0]};
		endcase
	endfunction

	// Phase that follows a header phase
	function automatic sfcfe_state_e after(input sfcfe_state_e ph,
		input sfcfe_phase_width_code_s d);
		sfcfe_state_e r;
		if (ph == ST_OP && d.has_addr) begin
			r = ST_ADDR;
		end else if (ph != ST_MODE && ph != ST_DUMMY && d.mode_clk != 0) begin
			r = ST_MODE;
		end else if (ph != ST_DUMMY && d.dummy_clk != 0) begin
			r = ST_DUMMY;
		end else if (d.dir == DIR_OUT) begin
			r = ST_DOUT;
		end else if (d.dir == DIR_IN) begin
			r = ST_DIN;
		end else begin
			r = ST_DONE;
		end
		return r;
	endfunction

	// Lane width of the phase now shifting in
	always_comb begin
		case (st.state)
			ST_ADDR, ST_MODE: lg = st.desc.ad_lg;
			ST_DIN: lg = st.desc.da_lg;
			default: lg = `SFCFE_LG1;
		endcase
		bits = shin(st.sh, pf.io, lg);
	end

	// Next output byte: fresh from the user or the old one shifted
	always_comb begin
		if (st.tx_cnt == 3'h0) begin
			cur = tx_data;
		end else begin
			case (st.desc.da_lg)
				`SFCFE_LG2: cur = {st.tx_sh[5:0], 2'h0};
				`SFCFE_LG4: cur = {st.tx_sh[3:0], 4'h0};
				default: cur = {st.tx_sh[6:0], 1'h0};
			endcase
		end
	end

	// ----------------------------------------
	// Frame state machine
	// ----------------------------------------

	// One pass per system clock; pulses default low
	always_comb begin
		n = st;
		n.sck_p = pf.sck;
		n.cmd_start = 1'h0;
		n.cmd_done = 1'h0;
		n.tx_next = 1'h0;
		n.rx.valid = 1'h0;
		n.er.valid = 1'h0;
		n.rst_p = 1'h0;
		if (pf.cs_n) begin
			// Deselect ends any frame and releases every lane
			n.state = ST_IDLE;
			n.drv.io_oe = 4'h0;
			n.hdr = 1'h0;
			if (st.state != ST_IDLE) begin
				// Reset enable only arms the very next frame
				n.armed = st.hdr && st.opcode == `SFCFE_OP_RST_EN;
				if (st.hdr) begin
					n.cmd_done = 1'h1;
					if (st.opcode == `SFCFE_OP_RST && st.armed) begin
						n.rst_p = 1'h1;
						n.cont = 1'h0;
					end
					// Erase granularity and aligned base
					n.er.valid = 1'h1;
					case (st.opcode)
						`SFCFE_OP_ER4K: begin
							n.er.size = ER_4K;
							n.er.base = st.addr & `SFCFE_ER4K_MASK;
						end
						`SFCFE_OP_ER32K: begin
							n.er.size = ER_32K;
							n.er.base = st.addr & `SFCFE_ER32K_MASK;
						end
						`SFCFE_OP_ER64K: begin
							n.er.size = ER_64K;
							n.er.base = st.addr & `SFCFE_ER64K_MASK;
						end
						`SFCFE_OP_CHIP_A, `SFCFE_OP_CHIP_B: begin
							n.er.size = ER_CHIP;
							n.er.base = '0;
						end
						default: begin
							n.er.valid = 1'h0;
						end
					endcase
				end
			end
		end else if (st.state == ST_IDLE) begin
			// Select seen: open a frame
			n.cnt = 6'h0;
			n.sh = 24'h00_0000;
			n.rise_cnt = 8'h00;
			n.tx_cnt = 3'h0;
			if (st.cont && desc_cand.ok) begin
				n.state = ST_ADDR;
				n.desc = desc_cand;
				n.opcode = st.cont_op;
				n.frame_cont = 1'h1;
			end else begin
				n.state = ST_OP;
				n.frame_cont = 1'h0;
			end
		end else begin
			if (rise) begin
				if (st.rise_cnt != 8'hFF) begin
					n.rise_cnt = st.rise_cnt + 8'h01;
				end
				n.cnt = st.cnt + 6'h01;
				case (st.state)
					ST_OP: begin
						n.sh = bits;
						if (st.cnt == 6'(`SFCFE_OP_BITS - 1)) begin
							if (!desc_cand.ok) begin
								n.state = ST_IGN;
							end else begin
								n.opcode = bits[7:0];
								n.desc = desc_cand;
								n.state = after(ST_OP, desc_cand);
							end
						end
					end
					ST_ADDR: begin
						n.sh = bits;
						if (st.cnt == 6'((`SFCFE_ADDR_BITS >> st.desc.ad_lg) - 1)) begin
							n.addr = bits[`SFCFE_ADDR_W-1:0];
							n.state = after(ST_ADDR, st.desc);
						end
					end
					ST_MODE: begin
						n.sh = bits;
						if (st.cnt == 6'(st.desc.mode_clk - 3'h1)) begin
							n.cont = bits[5:4] == `SFCFE_CONT_MODE;
							n.cont_op = st.opcode;
							n.state = after(ST_MODE, st.desc);
						end
					end
					ST_DUMMY: begin
						if (st.cnt == st.desc.dummy_clk - 6'h01) begin
							n.state = after(ST_DUMMY, st.desc);
						end
					end
					ST_DIN: begin
						n.sh = bits;
						if (st.cnt == 6'((`SFCFE_BYTE_BITS >> st.desc.da_lg) - 1)) begin
							n.rx.valid = 1'h1;
							n.rx.data = bits[7:0];
							n.cnt = 6'h0;
						end
					end
					default: begin
						n.cnt = st.cnt;
					end
				endcase
				if (n.state != st.state) begin
					n.cnt = 6'h0;
				end
				// Header complete: report it and ask for read data
				if (!st.hdr && (n.state == ST_DOUT || n.state == ST_DIN ||
					n.state == ST_DONE)) begin
					n.hdr = 1'h1;
					n.cmd_start = 1'h1;
					n.tx_next = n.state == ST_DOUT;
				end
			end
			// Output lanes only turn on at a falling edge in the data
			// phase, so the last mode or dummy clock is already past
			if (fall && st.state == ST_DOUT) begin
				n.tx_sh = cur;
				if (st.tx_cnt == 3'h0) begin
					n.tx_next = 1'h1;
					n.tx_cnt = 3'((`SFCFE_BYTE_BITS >> st.desc.da_lg) - 1);
				end else begin
					n.tx_cnt = st.tx_cnt - 3'h1;
				end
				case (st.desc.da_lg)
					`SFCFE_LG2: begin
						n.drv.io_out = {2'h0, cur[7:6]};
						n.drv.io_oe = 4'h3;
					end
					`SFCFE_LG4: begin
						n.drv.io_out = cur[7:4];
						n.drv.io_oe = 4'hF;
					end
					default: begin
						n.drv.io_out = {2'h0, cur[7], 1'h0};
						n.drv.io_oe = 4'h2;
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Upper lanes keep their pin roles unless quad is enabled
	assign protect_n = quad_enable_bit ? 1'h1 : pf.io[2];
	assign pause_n = quad_enable_bit ? 1'h1 : pf.io[3];
	assign pins_out = st.drv;
	assign cmd = '{start: st.cmd_start, done: st.cmd_done,
		cont: st.frame_cont, opcode: st.opcode, addr: st.addr};
	assign tx_next = st.tx_next;
	assign rx = st.rx;
	assign erase = st.er;
	assign dev_reset = st.rst_p;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_frame_end;
		$rose(pf.cs_n);
	endsequence
	sequence s_released;
		pins_out.io_oe == 4'h0 [*2];
	endsequence
	sequence s_header_done;
		cmd.start && !cmd.cont;
	endsequence

	property p_release;
		s_frame_end |=> s_released;
	endproperty
	property p_drive_phase;
		pins_out.io_oe != 4'h0 |-> st.state == ST_DOUT && st.hdr;
	endproperty
	property p_lanes(logic [1:0] w, logic [3:0] oe);
		pins_out.io_oe != 4'h0 && st.desc.da_lg == w |->
			pins_out.io_oe == oe;
	endproperty

	release_hiz_a: assert property (p_release)
		else $error("lanes still driven after deselect");
	drive_phase_a: assert property (p_drive_phase)
		else $error("lane driven outside the data phase");
	lane_single_a: assert property (p_lanes(`SFCFE_LG1, 4'h2))
		else $error("single read drives wrong lanes");
	lane_dual_a: assert property (p_lanes(`SFCFE_LG2, 4'h3))
		else $error("dual read drives wrong lanes");
	lane_quad_a: assert property (p_lanes(`SFCFE_LG4, 4'hF))
		else $error("quad read drives wrong lanes");
	ignore_hold_a: assert property (
		st.state == ST_IGN && !pf.cs_n |=> st.state == ST_IGN && !cmd.start)
		else $error("unsupported opcode left ignore state");
	done_header_a: assert property (
		cmd.done |-> $past(st.hdr))
		else $error("command done without full header");
	reset_armed_a: assert property (
		dev_reset |-> $past(st.armed) && $past(st.opcode) == `SFCFE_OP_RST)
		else $error("reset without preceding reset enable");
	erase_align_a: assert property (
		erase.valid && erase.size == ER_32K |-> erase.base[14:0] == 15'h0000)
		else $error("32k erase base not aligned");
	read_len_a: assert property (
		s_header_done ##0 cmd.opcode == `SFCFE_OP_READ |-> st.rise_cnt == 8'h20)
		else $error("plain read header not 32 clocks");
	qio_len_a: assert property (
		s_header_done ##0 cmd.opcode == `SFCFE_OP_QIO |-> st.rise_cnt == 8'h14)
		else $error("quad io header not 20 clocks");
	dio_len_a: assert property (
		s_header_done ##0 cmd.opcode == `SFCFE_OP_DIO |-> st.rise_cnt == 8'h18)
		else $error("dual io header not 24 clocks");
	cont_len_a: assert property (
		cmd.start && cmd.cont && cmd.opcode == `SFCFE_OP_QIO |->
			st.rise_cnt == 8'h0C)
		else $error("continuous quad header not 12 clocks");
	uid_len_a: assert property (
		s_header_done ##0 cmd.opcode == `SFCFE_OP_UID |-> st.rise_cnt == 8'h28)
		else $error("unique id header not 40 clocks");
endmodule

/* src/sfcfe_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfcfe_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] f;
	} sfcfe_sync_s;

	sfcfe_sync_s st;
	sfcfe_sync_s n;

	// A bit only moves once stages two and three agree, so a
	// metastable settle in stage two cannot leak out
	always_comb begin
		n = st;
		n.s1 = d_in;
		n.s2 = st.s1;
		n.s3 = st.s2;
		n.f = (st.s2 & st.s3) | (st.f & (st.s2 | st.s3));
	end

	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st <= n;
		end
	end

	assign d_out = st.f;
endmodule

/* testbench/sfcfe_host.sv */
// Host SPI master model that frames commands for the flash front end
`timescale 1ns/1ps
module sfcfe_host (
	input wire logic clock,
	input wire sfcfe_pkg::sfcfe_drive_s pins_out,
	output sfcfe_pkg::sfcfe_pins_s pins_in
);
	import sfcfe_pkg::*;
	logic cs_n = 1'b1;
	logic sck = 1'b0;
	logic [3:0] hv = 4'h0;
	logic [3:0] ho = 4'h0;
	logic flt = 1'b0;
	// Released lines 0 and 1 toggle so a stale value never looks valid
	always @(negedge clock) flt <= ~flt;
	// Wire level: device first, then host, else pull-up or toggle
	always_comb begin
		pins_in.cs_n = cs_n;
		pins_in.sck = sck;
		for (int i = 0; i < 4; i++)
			if (pins_out.io_oe[i]) pins_in.io[i] = pins_out.io_out[i];
			else if (ho[i]) pins_in.io[i] = hv[i];
			else pins_in.io[i] = (i > 1) ? 1'b1 : flt ^ i[0];
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Clock parked low between frames, so the first edge is a rise
	task automatic sel();
		wt(1);
		cs_n = 1'b0;
	endtask
	task automatic desel();
		sck = 1'b0;
		wt(3);
		ho = 4'h0;
		cs_n = 1'b1;
		wt(8);
	endtask
	// Long low phase lets device data settle before the rising sample
	task automatic shift(input logic [31:0] v, input int n, input int w,
		input logic drv, output logic [31:0] r);
		logic [3:0] m;
		m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
		r = '0;
		for (int k = 0; k < n; k += w) begin
			sck = 1'b0;
			ho = drv ? m : 4'h0;
			hv = 4'(v >> (n - k - w));
			wt(5);
			sck = 1'b1;
			r = (r << w) | (w == 1 ? 32'(pins_in.io[1]) : 32'(pins_in.io & m));
			wt(3);
		end
	endtask
	// Hold the protect and pause lines low while on
	task automatic wp(input logic on);
		ho = on ? 4'hC : 4'h0;
		hv = 4'h0;
	endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench of the flash command front end
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
$display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
	import sfcfe_pkg::*;
	typedef struct packed {
		logic [7:0] op;
		logic [23:0] a;
		logic [4:0] na;
		logic [5:0] dm;
		logic [2:0] w;
		logic [3:0] oe;
		logic [1:0] sz;
		logic [22:0] base;
	} sfcfe_row_s;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic quad_enable_bit = 1'b0;
	logic [7:0] tx_data = 8'hC6;
	sfcfe_pins_s pins_in;
	sfcfe_drive_s pins_out;
	sfcfe_cmd_s cmd;
	sfcfe_rx_s rx;
	sfcfe_erase_s erase;
	logic protect_n, pause_n, tx_next, dev_reset;
	int errors = 0, compares = 0, n_st = 0, n_dn = 0, n_er = 0, n_rs = 0;
	int s0, d0, e0, r0;
	logic [1:0] es;
	logic [22:0] eb;
	logic [7:0] rxd;
	int n_rx = 0, n_tx = 0, x0, t0;
	logic [3:0] oe_seen;
	logic [31:0] r;
	// Rows: opcode, address, address bits, dummy, lanes, enables, erase
	sfcfe_row_s rows [11] = '{
		'{8'h20, 24'h92_3456, 5'h18, 6'h00, 3'h0, 4'h0, 2'h0, 23'h12_3000},
		'{8'h52, 24'hFF_FFFF, 5'h18, 6'h00, 3'h0, 4'h0, 2'h1, 23'h7F_8000},
		'{8'hD8, 24'h00_FFFF, 5'h18, 6'h00, 3'h0, 4'h0, 2'h2, 23'h00_0000},
		'{8'hC7, 24'h00_0000, 5'h00, 6'h00, 3'h0, 4'h0, 2'h3, 23'h00_0000},
		'{8'h60, 24'h00_0000, 5'h00, 6'h00, 3'h0, 4'h0, 2'h3, 23'h00_0000},
		'{8'h03, 24'h12_3456, 5'h18, 6'h00, 3'h1, 4'h2, 2'h0, 23'h00_0000},
		'{8'h0B, 24'h65_4321, 5'h18, 6'h08, 3'h1, 4'h2, 2'h0, 23'h00_0000},
		'{8'h3B, 24'h00_0010, 5'h18, 6'h08, 3'h2, 4'h3, 2'h0, 23'h00_0000},
		'{8'h6B, 24'h7F_FFF0, 5'h18, 6'h08, 3'h4, 4'hF, 2'h0, 23'h00_0000},
		'{8'h05, 24'h00_0000, 5'h00, 6'h00, 3'h1, 4'h2, 2'h0, 23'h00_0000},
		'{8'h4B, 24'h00_0000, 5'h00, 6'h20, 3'h1, 4'h2, 2'h0, 23'h00_0000}
	};
	sfcfe_front_end u_dut (.clock(clock), .sys_rst(sys_rst),
		.pins_in(pins_in), .quad_enable_bit(quad_enable_bit),
		.tx_data(tx_data), .pins_out(pins_out), .protect_n(protect_n),
		.pause_n(pause_n), .cmd(cmd), .tx_next(tx_next), .rx(rx),
		.erase(erase), .dev_reset(dev_reset));
	sfcfe_host u_host (.clock(clock), .pins_out(pins_out), .pins_in(pins_in));
	always #10 clock = ~clock;
	// Pulse counters; case equality keeps unknowns from counting
	always @(posedge clock) begin
		if (cmd.start === 1'b1) n_st++;
		if (cmd.done === 1'b1) n_dn++;
		if (dev_reset === 1'b1) n_rs++;
		if (tx_next === 1'b1) n_tx++;
		if (rx.valid === 1'b1) begin
			n_rx++;
			rxd = rx.data;
		end
		if (erase.valid === 1'b1) begin
			n_er++;
			es = erase.size;
			eb = erase.base;
		end
	end
	task automatic test_done();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One whole frame; enables are captured before chip select rises
	task automatic frame(input logic [7:0] op, input int na,
		input logic [23:0] a, input int dm, input int w);
		logic [31:0] t;
		u_host.sel();
		u_host.shift(32'(op), 8, 1, 1'b1, t);
		if (na > 0) u_host.shift(32'(a >> (24 - na)), na, 1, 1'b1, t);
		if (dm > 0) u_host.shift('0, dm, 1, 1'b1, t);
		if (w > 0) u_host.shift('0, 8, w, 1'b0, r);
		oe_seen = pins_out.io_oe;
		u_host.desel();
	endtask
	// Wide address read with a mode byte; skip leaves the opcode out
	task automatic xip(input logic [7:0] op, input logic [7:0] md,
		input int w, input int dm, input logic skip);
		u_host.sel();
		if (!skip) u_host.shift(32'(op), 8, 1, 1'b1, r);
		u_host.shift(32'h0012_3456, 24, w, 1'b1, r);
		u_host.shift(32'(md), 8, w, 1'b1, r);
		if (dm > 0) u_host.shift('0, dm, 1, 1'b1, r);
		u_host.shift('0, 8, w, 1'b0, r);
		oe_seen = pins_out.io_oe;
		u_host.desel();
	endtask
	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (40000) @(posedge clock);
		errors++;
		test_done();
	end
	initial begin
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		repeat (5) @(negedge clock);
		quad_enable_bit = 1'b1;
		foreach (rows[i]) begin
			s0 = n_st;
			d0 = n_dn;
			e0 = n_er;
			t0 = n_tx;
			frame(rows[i].op, rows[i].na, rows[i].a, rows[i].dm, rows[i].w);
			`CHK("start", s0 + 1, n_st)
			`CHK("done", d0 + 1, n_dn)
			`CHK("erase", e0 + (rows[i].w == 0), n_er)
			if (rows[i].w == 0) begin
				`CHK("size", rows[i].sz, es)
				`CHK("base", rows[i].base, eb)
			end else begin
				`CHK("data", 32'h0000_00C6, r)
				`CHK("lanes", rows[i].oe, oe_seen)
			end
			if (rows[i].na != 0) `CHK("addr", rows[i].a[22:0], cmd.addr)
			`CHK("idle oe", 4'h0, pins_out.io_oe)
			`CHK("tx next", t0 + 3 * (rows[i].w != 0), n_tx)
			`CHK("opcode", rows[i].op, cmd.opcode)
		end
		$display("table rows done");
		// Address-first reads: mode 10 arms the next frame, 00 clears
		s0 = n_st;
		xip(8'hBB, 8'h20, 2, 0, 1'b0);
		`CHK("dual io data", 32'h0000_00C6, r)
		`CHK("dual io lanes", 4'h3, oe_seen)
		xip(8'h00, 8'h00, 2, 0, 1'b1);
		`CHK("dual cont", 1'b1, cmd.cont)
		`CHK("dual cont op", 8'hBB, cmd.opcode)
		xip(8'hEB, 8'h20, 4, 4, 1'b0);
		`CHK("quad io data", 32'h0000_00C6, r)
		`CHK("quad io lanes", 4'hF, oe_seen)
		xip(8'h00, 8'h00, 4, 4, 1'b1);
		`CHK("quad cont", 1'b1, cmd.cont)
		`CHK("quad cont addr", 23'h12_3456, cmd.addr)
		xip(8'hEB, 8'h00, 4, 4, 1'b0);
		`CHK("cont cleared", 1'b0, cmd.cont)
		`CHK("xip starts", s0 + 5, n_st)
		$display("continuous read test done");
		// Unknown opcode, quad read with lanes off, then a cut header
		quad_enable_bit = 1'b0;
		s0 = n_st;
		d0 = n_dn;
		e0 = n_er;
		frame(8'hFF, 24, 24'h20_0000, 8, 0);
		frame(8'h6B, 24, 24'h00_0000, 8, 0);
		frame(8'h20, 8, 24'h12_0000, 0, 0);
		`CHK("refused start", s0, n_st)
		`CHK("refused done", d0, n_dn)
		`CHK("refused erase", e0, n_er)
		$display("refusal test done");
		r0 = n_rs;
		frame(8'h66, 0, 24'h00_0000, 0, 0);
		frame(8'h99, 0, 24'h00_0000, 0, 0);
		`CHK("reset", r0 + 1, n_rs)
		frame(8'h99, 0, 24'h00_0000, 0, 0);
		`CHK("lone reset", r0 + 1, n_rs)
		$display("reset test done");
		// Status write: one data byte follows the opcode
		x0 = n_rx;
		u_host.sel();
		u_host.shift(32'h0000_0001, 8, 1, 1'b1, r);
		u_host.shift(32'h0000_00A5, 8, 1, 1'b1, r);
		u_host.desel();
		`CHK("rx count", x0 + 1, n_rx)
		`CHK("rx data", 8'hA5, rxd)
		$display("write test done");
		u_host.wp(1'b1);
		repeat (6) @(negedge clock);
		`CHK("protect", 1'b0, protect_n)
		`CHK("pause", 1'b0, pause_n)
		quad_enable_bit = 1'b1;
		repeat (2) @(negedge clock);
		`CHK("protect quad", 1'b1, protect_n)
		`CHK("pause quad", 1'b1, pause_n)
		u_host.wp(1'b0);
		$display("protect test done");
		test_done();
	end
endmodule
